// *** hw/iox_device.sv ***
// Purpose: Expander target end: address match, command, register access.
// Assumes: Link lines sampled by mclk through two flip-flops each.
// Notes: Holds output, polarity and direction registers.
`timescale 1ns/1ps
module iox_device (
  input wire logic mclk,
  input wire logic rst,
  iox_link_if.device link,
  input wire logic [2:0] address_select_pins,
  input wire logic [7:0] port_in,
  output logic [7:0] port_out,
  output logic [7:0] port_oe,
  output logic [7:0] polarity,
  output logic [7:0] command
);
  typedef enum {D_IDLE, D_ADDR, D_CMD, D_WDATA, D_RDATA, D_IGNORE}
    iox_dstate_t;
  iox_dstate_t state;
  logic scl_s1;
  logic scl_s2;
  logic scl_d;
  logic sda_s1;
  logic sda_s2;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [3:0] bitn;
  logic [7:0] shin;
  logic [7:0] shout;
  logic ack_phase;
  logic master_nack;
  logic data_ack;
  logic [2:0] sel_s1;
  logic [2:0] sel_s2;
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] config_reg;
  logic [7:0] rd_value;
  logic addr_match;
  logic sda_low;
  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign start_cond = scl_s2 && scl_d && sda_d && !sda_s2;
  assign stop_cond = scl_s2 && scl_d && !sda_d && sda_s2;
  assign addr_match = (shin[7:1] == {iox_pkg::ADDR_FIXED,
                                     sel_s2});
  assign port_oe = ~config_reg;
  assign link.sda_o_d = 1'b0;
  assign link.sda_oe_d = sda_low;
  always_comb
  begin
    // Register picked by the two low command bits.
    case (command[1:0])
      iox_pkg::REG_INPUT: rd_value = pin_s2 ^ polarity;
      iox_pkg::REG_OUTPUT: rd_value = port_out;
      iox_pkg::REG_POLARITY: rd_value = polarity;
      default: rd_value = config_reg;
    endcase
  end
  // ----------------------------------------
  // Line synchronisers and edge finding.
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      sel_s1 <= 3'h0;
      sel_s2 <= 3'h0;
      pin_s1 <= 8'h00;
      pin_s2 <= 8'h00;
    end
    else
    begin
      scl_s1 <= link.scl;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      sel_s1 <= address_select_pins;
      sel_s2 <= sel_s1;
      pin_s1 <= port_in;
      pin_s2 <= pin_s1;
    end
  end
  // ----------------------------------------
  // Transaction state machine.
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= D_IDLE;
      bitn <= 4'h0;
      shin <= 8'h00;
      shout <= 8'hff;
      ack_phase <= 1'b0;
      master_nack <= 1'b0;
      data_ack <= 1'b0;
      sda_low <= 1'b0;
    end
    else if (stop_cond)
    begin
      // Partial byte dropped; stored registers untouched.
      state <= D_IDLE;
      bitn <= 4'h0;
      ack_phase <= 1'b0;
      data_ack <= 1'b0;
      sda_low <= 1'b0;
    end
    else if (start_cond)
    begin
      // Restart leaves command untouched.
      state <= D_ADDR;
      bitn <= 4'h0;
      ack_phase <= 1'b0;
      data_ack <= 1'b0;
      sda_low <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (ack_phase)
        master_nack <= sda_s2;
      else
      begin
        shin <= {shin[6:0], sda_s2};
        bitn <= bitn + 4'h1;
      end
    end
    else if (scl_fall)
    begin
      if (ack_phase)
      begin
        ack_phase <= 1'b0;
        data_ack <= 1'b0;
        sda_low <= 1'b0;
        if (state == D_RDATA)
        begin
          if (master_nack)
            state <= D_IGNORE;
          else
          begin
            shout <= {rd_value[6:0], 1'b1};
            sda_low <= !rd_value[7];
          end
        end
      end
      else if (bitn == 4'(iox_pkg::BITS_PER_BYTE))
      begin
        bitn <= 4'h0;
        ack_phase <= 1'b1;
        // Only bytes after the command byte are register data.
        data_ack <= (state == D_WDATA);
        sda_low <= 1'b0;
        case (state)
          D_ADDR:
          begin
            if (addr_match)
            begin
              sda_low <= 1'b1;
              state <= shin[0] ? D_RDATA : D_CMD;
              shout <= rd_value;
            end
            else
              state <= D_IGNORE;
          end
          D_CMD:
          begin
            sda_low <= 1'b1;
            state <= D_WDATA;
          end
          D_WDATA:
            sda_low <= 1'b1;
          default:
            sda_low <= 1'b0;
        endcase
      end
      else if (state == D_RDATA)
      begin
        sda_low <= !shout[7];
        shout <= {shout[6:0], 1'b1};
      end
    end
  end
  // ----------------------------------------
  // Command and register storage.
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      command <= iox_pkg::RST_COMMAND;
      port_out <= iox_pkg::RST_OUTPUT;
      polarity <= iox_pkg::RST_POLARITY;
      config_reg <= iox_pkg::RST_CONFIG;
    end
    else if (scl_rise && ack_phase && !stop_cond && !start_cond)
    begin
      if (data_ack && bitn == 4'h0 && sda_low)
      begin
        // Byte lands on the ack clock rise.
        case (command[1:0])
          iox_pkg::REG_OUTPUT: port_out <= shin;
          iox_pkg::REG_POLARITY: polarity <= shin;
          iox_pkg::REG_CONFIG: config_reg <= shin;
          default: config_reg <= config_reg;
        endcase
      end
    end
    else if (scl_fall && state == D_CMD && !ack_phase &&
             bitn == 4'(iox_pkg::BITS_PER_BYTE))
      command <= shin;
  end
endmodule : iox_device

// *** hw/iox_master.sv ***
// Purpose: Link master end issuing register writes and reads.
// Assumes: Pull-ups on both lines; link clock derived from mclk.
// Notes: One byte per request; start/restart/stop chosen per request.
`timescale 1ns/1ps
module iox_master #(
  parameter int QUARTER = iox_pkg::SCL_QUARTER
) (
  input wire logic mclk,
  input wire logic rst,
  iox_link_if.master link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_start,
  input wire logic req_stop,
  input wire logic req_read,
  input wire logic req_last,
  input wire logic [7:0] req_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  typedef enum {M_IDLE, M_START, M_BIT, M_STOP} iox_mstate_t;
  iox_mstate_t state;
  logic [15:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [8:0] shreg;
  logic rd;
  logic stop_after;
  logic scl_drive_low;
  logic sda_drive_low;
  logic sda_s1;
  logic sda_s2;
  logic tick;
  // The quarter count must fit the divider counter.
  if (QUARTER < 1 || QUARTER > 2 ** $bits(qcnt))
  begin : g_quarter_check
    $error("QUARTER must lie between one and the counter range");
  end
  assign tick = (qcnt == 16'(QUARTER - 1));
  assign req_ready = (state == M_IDLE);
  assign link.scl_o_m = 1'b0;
  assign link.sda_o_m = 1'b0;
  assign link.scl_oe_m = scl_drive_low;
  assign link.sda_oe_m = sda_drive_low;
  // ----------------------------------------
  // Synchroniser for the data line.
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end
    else
    begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      qcnt <= '0;
    else if (state == M_IDLE || tick)
      qcnt <= '0;
    else
      qcnt <= qcnt + 16'h0001;
  end
  // ----------------------------------------
  // Byte sequencer.
  // ----------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= M_IDLE;
      phase <= 2'h0;
      bitn <= 4'h0;
      shreg <= 9'h1ff;
      rd <= 1'b0;
      stop_after <= 1'b0;
      scl_drive_low <= 1'b0;
      sda_drive_low <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state)
        M_IDLE:
        begin
          if (req_valid)
          begin
            rd <= req_read;
            stop_after <= req_stop;
            // Read bytes shift all ones; ack bit low unless last.
            shreg <= req_read ? {8'hff, req_last} : {req_data, 1'b1};
            phase <= 2'h0;
            bitn <= 4'h0;
            state <= req_start ? M_START : M_BIT;
          end
        end
        M_START:
        begin
          if (tick)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_drive_low <= 1'b0;
              2'h1: scl_drive_low <= 1'b0;
              2'h2: sda_drive_low <= 1'b1;
              default:
              begin
                scl_drive_low <= 1'b1;
                state <= M_BIT;
              end
            endcase
          end
        end
        M_BIT:
        begin
          if (tick)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_drive_low <= !shreg[8];
              2'h1: scl_drive_low <= 1'b0;
              2'h2: shreg <= {shreg[7:0], sda_s2};
              default:
              begin
                scl_drive_low <= 1'b1;
                if (bitn == 4'(iox_pkg::BITS_PER_BYTE))
                begin
                  rsp_valid <= 1'b1;
                  rsp_data <= rd ? shreg[8:1] : 8'h00;
                  rsp_nack <= shreg[0];
                  bitn <= 4'h0;
                  state <= stop_after ? M_STOP : M_IDLE;
                end
                else
                  bitn <= bitn + 4'h1;
              end
            endcase
          end
        end
        M_STOP:
        begin
          if (tick)
          begin
            phase <= phase + 2'h1;
            case (phase)
              2'h0: sda_drive_low <= 1'b1;
              2'h1: scl_drive_low <= 1'b0;
              2'h2: sda_drive_low <= 1'b0;
              default: state <= M_IDLE;
            endcase
          end
        end
        default: state <= M_IDLE;
      endcase
    end
  end
endmodule : iox_master

// *** inc/iox_link_if.sv ***
// Purpose: Two-wire link joining the master end and the expander end.
// Assumes: Both lines are open drain with pull-ups.
// Notes: Line levels are resolved from the output enables.
`timescale 1ns/1ps
interface iox_link_if;
  logic scl_o_m;
  logic scl_oe_m;
  logic sda_o_m;
  logic sda_oe_m;
  logic sda_o_d;
  logic sda_oe_d;
  logic scl;
  logic sda;
  assign scl = !(scl_oe_m && !scl_o_m);
  assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_d && !sda_o_d));
  modport master (output scl_o_m, output scl_oe_m, output sda_o_m,
                  output sda_oe_m, input scl, input sda);
  modport device (output sda_o_d, output sda_oe_d, input scl, input sda);
endinterface : iox_link_if

// *** inc/iox_pkg.sv ***
// Purpose: Shared constants for the I/O expander serial link ends.
// Assumes: One system clock at 100 MHz; link clock made by the master end.
// Notes: Register map and reset values of the expander registers.
package iox_pkg;
  localparam logic [3:0] ADDR_FIXED = 4'h3;
  localparam logic [1:0] REG_INPUT = 2'h0;
  localparam logic [1:0] REG_OUTPUT = 2'h1;
  localparam logic [1:0] REG_POLARITY = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;
  localparam logic [7:0] RST_OUTPUT = 8'h00;
  localparam logic [7:0] RST_POLARITY = 8'hf0;
  localparam logic [7:0] RST_CONFIG = 8'hff;
  localparam logic [7:0] RST_COMMAND = 8'h00;
  localparam int CLK_MHZ = 100;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QUARTER = (SCL_PERIOD_NS * CLK_MHZ + 3999) / 4000;
  localparam int BITS_PER_BYTE = 8;
endpackage : iox_pkg

// *** verif/iox_checker.sv ***
// Purpose: Wire-level checks on the expander link.
// Assumes: Lines sampled by mclk; device acks a matching address and each write byte.
// Notes: Tracks bit position from start conditions.
`timescale 1ns/1ps
module iox_checker (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl_o_m,
  input wire logic scl_oe_m,
  input wire logic sda_o_m,
  input wire logic sda_oe_m,
  input wire logic sda_o_d,
  input wire logic sda_oe_d,
  input wire logic scl,
  input wire logic sda
);
  logic s_scl, s_sda, fb, rw, hit, nk, rise, sta, sto, ack;
  logic [3:0] bitn;
  assign rise = scl && !s_scl;
  assign sta = scl && s_scl && s_sda && !sda;
  assign sto = scl && s_scl && !s_sda && sda;
  assign ack = rise && bitn == 4'h8;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // Keeps the previous line levels.
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      s_scl <= 1'b1;
      s_sda <= 1'b1;
    end
    else
    begin
      s_scl <= scl;
      s_sda <= sda;
    end
  // Follows bit count, direction, match and end of read.
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      {fb, rw, hit, nk} <= 4'h0;
      bitn <= 4'h0;
    end
    else if (sta)
    begin
      {fb, rw, hit, nk} <= 4'h8;
      bitn <= 4'h0;
    end
    else if (rise)
    begin
      bitn <= ack ? 4'h0 : bitn + 4'h1;
      if (fb && bitn == 4'h7) rw <= sda;
      if (ack && fb) hit <= !sda;
      if (ack) fb <= 1'b0;
      if (ack && !fb && rw && hit && sda) nk <= 1'b1;
    end
  property p_pull;
    sda_oe_d && !rw |-> (bitn == 4'h8 || bitn == 4'h0) && !sda_o_d;
  endproperty
  a_pull: assert property (p_pull) else $error("sda driven high");
  property p_hold;
    scl && $past(scl) |-> $stable(sda_oe_d);
  endproperty
  a_hold: assert property (p_hold) else $error("sda moved");
  property p_addr;
    fb && bitn < 4'h8 |-> !sda_oe_d;
  endproperty
  a_addr: assert property (p_addr) else $error("early drive");
  property p_wdat;
    !fb && !rw && bitn != 4'h0 && bitn < 4'h8 |-> !sda_oe_d;
  endproperty
  a_wdat: assert property (p_wdat) else $error("write clash");
  property p_wack;
    ack && hit && !fb && !rw |-> !sda;
  endproperty
  a_wack: assert property (p_wack) else $error("no data ack");
  property p_rrel;
    ack && rw && !fb |-> !sda_oe_d;
  endproperty
  a_rrel: assert property (p_rrel) else $error("ack slot held");
  property p_nack;
    nk |-> !sda_oe_d;
  endproperty
  a_nack: assert property (p_nack) else $error("sent after nack");
  property p_stop;
    sto |=> !sda_oe_d [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("drive after stop");
  c_wr: cover property (ack && hit && !fb && !rw);
  c_nk: cover property (ack && hit && !fb && rw && sda);
  c_st: cover property (sto);
endmodule : iox_checker

// *** verif/iox_tb_top.sv ***
// Purpose: Self-checking bench joining master and expander ends.
// Assumes: QUARTER of 5 keeps link bytes short.
// Notes: Responses are matched in order against a queue.
`timescale 1ns/1ps
module iox_tb_top;
  logic mclk, rst, req_valid, req_ready, req_start, req_stop;
  logic req_read, req_last, rsp_valid, rsp_nack;
  logic [7:0] req_data, rsp_data, port_in, port_out, port_oe;
  logic [7:0] polarity, command, d, cmd, aw, ar;
  logic [7:0] rv[4];
  logic [2:0] pins;
  logic [8:0] exp_q[$];
  int errors, samples_checked, seed, k, n;
  iox_link_if link ();
  iox_master #(.QUARTER(5)) iox_master_inst (.mclk(mclk), .rst(rst),
    .link(link), .req_valid(req_valid), .req_ready(req_ready),
    .req_start(req_start), .req_stop(req_stop), .req_read(req_read),
    .req_last(req_last), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  iox_device iox_device_inst (.mclk(mclk), .rst(rst), .link(link),
    .address_select_pins(pins), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .polarity(polarity), .command(command));
  iox_checker iox_checker_inst (.mclk(mclk), .rst(rst),
    .scl_o_m(link.scl_o_m), .scl_oe_m(link.scl_oe_m),
    .sda_o_m(link.sda_o_m), .sda_oe_m(link.sda_oe_m),
    .sda_o_d(link.sda_o_d), .sda_oe_d(link.sda_oe_d),
    .scl(link.scl), .sda(link.sda));
  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [8:0] got, input logic [8:0] want);
    samples_checked++;
    if (got !== want)
    begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, want);
    end
  endtask : chk
  task automatic xf(input logic s, input logic p, input logic r,
    input logic l, input logic [7:0] b, input logic [8:0] x);
    while (req_ready !== 1'b1)
      @(negedge mclk);
    {req_start, req_stop, req_read, req_last, req_data} = {s, p, r, l, b};
    req_valid = 1'b1;
    exp_q.push_back(x);
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : xf
  task automatic fin();
    while (exp_q.size() != 0 || req_ready !== 1'b1)
      @(negedge mclk);
  endtask : fin
  task automatic regs();
    chk({1'b0, port_out}, {1'b0, rv[1]});
    chk({1'b0, polarity}, {1'b0, rv[2]});
    chk({1'b0, port_oe}, {1'b0, ~rv[3]});
    chk({1'b0, command}, {1'b0, cmd});
  endtask : regs
  always @(negedge mclk)
    if (rsp_valid === 1'b1)
      chk({rsp_nack, rsp_data}, exp_q.pop_front());
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #600000;
    errors++;
    tally_and_finish();
  end
  initial
  begin
    seed = 17;
    {req_valid, req_start, req_stop, req_read, req_last} = 5'h00;
    req_data = 8'h00;
    pins = 3'($random(seed));
    port_in = 8'($random(seed));
    aw = {iox_pkg::ADDR_FIXED, pins, 1'b0};
    ar = aw | 8'h01;
    rv[1] = iox_pkg::RST_OUTPUT;
    rv[2] = iox_pkg::RST_POLARITY;
    rv[3] = iox_pkg::RST_CONFIG;
    cmd = iox_pkg::RST_COMMAND;
    rst = 1'b1;
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    regs();
    for (k = 0; k < 4; k++)
    begin
      xf(1, 0, 0, 0, aw, 9'h000);
      xf(0, 0, 0, 0, k[7:0], 9'h000);
      for (n = 0; n < 3; n++)
      begin
        d = 8'($random(seed));
        xf(0, n == 2, 0, 0, d, 9'h000);
        if (k != 0)
          rv[k] = d;
      end
      cmd = k[7:0];
      fin();
      regs();
      rv[0] = port_in ^ rv[2];
      xf(1, 0, 0, 0, aw, 9'h000);
      xf(0, 0, 0, 0, k[7:0], 9'h000);
      xf(1, 0, 0, 0, ar, 9'h000);
      xf(0, 0, 1, 0, 8'h00, {1'b0, rv[k]});
      xf(0, 1, 1, 1, 8'h00, {1'b1, rv[k]});
    end
    xf(1, 0, 0, 0, ar, 9'h000);
    xf(0, 1, 1, 1, 8'h00, {1'b1, rv[3]});
    xf(1, 1, 0, 0, aw ^ 8'h02, 9'h100);
    xf(1, 0, 0, 0, aw, 9'h000);
    xf(0, 1, 0, 0, 8'h01, 9'h000);
    cmd = 8'h01;
    fin();
    regs();
    tally_and_finish();
  end
endmodule : iox_tb_top
